/* rtl/pdss_burst.sv */
// two-bit burst address generator, linear or interleaved
`timescale 1ns/1ps
module pdss_burst
   import pdss_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               reset_n,
   input  wire logic               load,
   input  wire logic [BURST_W-1:0] load_bits,
   input  wire logic               step,
   input  wire logic               interleave,
   output logic      [BURST_W-1:0] low_bits
);
   logic [BURST_W-1:0] base_reg;   // loaded low address
   logic [BURST_W-1:0] count_reg;  // steps taken since load
   // look ahead on a step so the advanced word is read in the advance cycle
   wire  [BURST_W-1:0] count_use = step ? BURST_W'(count_reg + BURST_ONE) : count_reg;
   // xor form gives the interleaved order, sum gives linear
   assign low_bits = interleave ? (base_reg ^ count_use)
                                : BURST_W'(base_reg + count_use);

   // load wins over step: a new address restarts the burst
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         base_reg  <= '0;
         count_reg <= '0;
      end else if (load) begin
         base_reg  <= load_bits;
         count_reg <= '0;
      end else if (step) begin
         count_reg <= count_reg + BURST_ONE;
      end
   end
endmodule

/* rtl/pdss_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module pdss_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];    // storage words
   logic [PW:0]      wr_ptr_reg;     // extra bit tells full from empty
   logic [PW:0]      rd_ptr_reg;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   wire              ptr_same = wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0];

   assign in_ready  = !(ptr_same && (wr_ptr_reg[PW] != rd_ptr_reg[PW]));
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data  = mem[rd_ptr_reg[PW-1:0]];

   // pointers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clock) begin
      if (push) mem[wr_ptr_reg[PW-1:0]] <= in_data;
   end
endmodule

/* rtl/pdss_pkg.sv */
// shared constants and carrier types for the pipelined sync sram port
// Notes on behaviour
// - all synchronous inputs registered on rising clock
// - address loads only when a strobe is active
// - address captured only if all enables active
// - captured address selects one of 256K words
// - 32-bit words on common data lines
// - two-bit burst counter loaded from low address
// - burst addresses generated internally under advance
// - advance low steps counter, high holds it
// - linear or interleaved order, pin selectable
// - registered in and out, 3-1-1-1 burst
// - read data driven from output registers
// - writes registered then completed self-timed
// - one to four byte lanes written
// - lane written when select and enable low
// - global write low writes all lanes
// - output drive held one extra deselect cycle
// - processor strobe ignored while primary select high
// - third enable optional on two-enable variant
// - output enable and sleep act asynchronously; here both pass a two-flop synchroniser first
// - both strobes active, processor strobe wins
// - output enable masked first read cycle after deselect
// - sleep high holds data, low power
// - second enable active high, combines with others
package pdss_pkg;
   localparam int ADDR_W       = 18;   // 256K words
   localparam int DATA_W       = 32;   // word width
   localparam int LANES        = 4;    // byte lanes
   localparam int BURST_W      = 2;    // burst counter width
   localparam int FIFO_DEPTH   = 16;   // write data buffer depth
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1; // counter step

   // one registered bus cycle of control and data
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lane_we;
      logic [DATA_W-1:0] data;
   } pdss_wr_t;
endpackage

/* rtl/pdss_top.sv */
// pipelined double-cycle-deselect synchronous sram device core
`timescale 1ns/1ps
module pdss_top
   import pdss_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] dq_in,
   output logic      [DATA_W-1:0] dq_out,
   output logic                   dq_oe,
   input  wire logic              proc_addr_strobe_n,
   input  wire logic              ctrl_addr_strobe_n,
   input  wire logic              burst_advance_n,
   input  wire logic              chip_sel_primary_n,
   input  wire logic              chip_sel_expand_hi,
   input  wire logic              chip_sel_expand_lo_n,
   input  wire logic              lane0_write_sel_n,
   input  wire logic              lane1_write_sel_n,
   input  wire logic              lane2_write_sel_n,
   input  wire logic              lane3_write_sel_n,
   input  wire logic              lane_write_enable_n,
   input  wire logic              all_lanes_write_n,
   input  wire logic              output_enable_n,
   input  wire logic              sleep_request,
   input  wire logic              burst_interleave,
   input  wire logic              three_enable_variant,
   output logic                   sleep_active,
   output logic                   wr_buffer_full
);
   // input capture registers, one stage from the pins
   logic [ADDR_W-1:0] addr_pin_reg;
   logic [DATA_W-1:0] data_pin_reg;
   logic              proc_addr_strobe_n_reg, ctrl_addr_strobe_n_reg, adv_reg;
   logic              ce1_reg, ce2_reg, ce3_reg;
   logic [LANES-1:0]  lane_sel_reg;
   logic              lane_en_reg, gw_reg;
   logic              sleep_s1_reg, sleep_s2_reg;  // sleep synchroniser
   logic              oe_s1_reg, oe_s2_reg;        // output enable synchroniser
   logic              cfg_il_reg, cfg_three_reg;   // strap levels, static

   // input register bank
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         proc_addr_strobe_n_reg <= 1'b0;
         ctrl_addr_strobe_n_reg <= 1'b0;
         adv_reg  <= 1'b0;
         ce1_reg  <= 1'b0;
         ce2_reg  <= 1'b0;
         ce3_reg  <= 1'b0;
         lane_en_reg  <= 1'b0;
         gw_reg       <= 1'b0;
         lane_sel_reg <= '0;
         addr_pin_reg <= '0;
         data_pin_reg <= '0;
      end else begin
         proc_addr_strobe_n_reg <= !proc_addr_strobe_n;
         ctrl_addr_strobe_n_reg <= !ctrl_addr_strobe_n;
         adv_reg  <= !burst_advance_n;
         ce1_reg  <= !chip_sel_primary_n;
         ce2_reg  <= chip_sel_expand_hi;
         ce3_reg  <= !chip_sel_expand_lo_n;
         lane_en_reg  <= !lane_write_enable_n;
         gw_reg       <= !all_lanes_write_n;
         lane_sel_reg <= ~{lane3_write_sel_n, lane2_write_sel_n, lane1_write_sel_n, lane0_write_sel_n};
         addr_pin_reg <= addr_in;
         data_pin_reg <= dq_in;
      end
   end

   // asynchronous pins pass two flops before use, straps pass one
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
         oe_s1_reg    <= 1'b0;
         oe_s2_reg    <= 1'b0;
         cfg_il_reg   <= 1'b0;
         cfg_three_reg <= 1'b0;
      end else begin
         sleep_s1_reg <= sleep_request;
         sleep_s2_reg <= sleep_s1_reg;
         oe_s1_reg    <= !output_enable_n;
         oe_s2_reg    <= oe_s1_reg;
         cfg_il_reg   <= burst_interleave;
         cfg_three_reg <= three_enable_variant;
      end
   end

   // decode of the registered controls
   wire ce3_ok   = !cfg_three_reg || ce3_reg;
   wire sel_all  = ce1_reg && ce2_reg && ce3_ok;
   wire proc_addr_strobe_n_ok  = proc_addr_strobe_n_reg && ce1_reg;
   wire ctrl_addr_strobe_n_use = ctrl_addr_strobe_n_reg && !proc_addr_strobe_n_ok;
   wire strobe   = proc_addr_strobe_n_ok || ctrl_addr_strobe_n_use;
   wire start    = strobe && sel_all && !sleep_s2_reg;
   wire deselect = strobe && !start;
   // processor strobe cycles never write; writes come with ctrl_addr_strobe_n or later
   wire [LANES-1:0] lanes = gw_reg ? {LANES{1'b1}} :
                            (lane_en_reg ? lane_sel_reg : '0);
   logic active_reg;          // a burst is selected
   logic first_reg;           // first read word after a start from deselect
   logic [ADDR_W-1:0] base_addr_reg;
   wire  in_burst  = active_reg && !strobe;
   wire  step      = in_burst && adv_reg;
   wire  is_write  = (active_reg || start) && !proc_addr_strobe_n_ok && (|lanes);
   wire  is_read   = (start || in_burst) && !is_write;
   wire [BURST_W-1:0] low_bits;

   pdss_burst u_burst (
      .clock      (clock),
      .reset_n    (reset_n),
      .load       (start),
      .load_bits  (addr_pin_reg[BURST_W-1:0]),
      .step       (step),
      .interleave (cfg_il_reg),
      .low_bits   (low_bits)
   );

   // burst state and captured upper address
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         active_reg    <= 1'b0;
         first_reg     <= 1'b0;
         base_addr_reg <= '0;
      end else begin
         if (start) base_addr_reg <= addr_pin_reg;
         if (start) active_reg <= 1'b1;
         else if (deselect || sleep_s2_reg) active_reg <= 1'b0;
         first_reg <= start && !active_reg;
      end
   end

   // address currently in use, with low bits from the counter
   wire [ADDR_W-1:0] cur_addr = start ? addr_pin_reg
                                : {base_addr_reg[ADDR_W-1:BURST_W], low_bits};

   // write requests pass through the fifo, the array drains it
   pdss_wr_t wr_req, wr_head;
   logic     wr_valid, wr_in_ready;
   assign wr_req = '{addr: cur_addr, lane_we: lanes, data: data_pin_reg};
   pdss_fifo #(.WIDTH($bits(pdss_wr_t)), .DEPTH(FIFO_DEPTH)) u_wfifo (
      .clock     (clock),
      .reset_n   (reset_n),
      .in_data   (wr_req),
      .in_valid  (is_write),
      .in_ready  (wr_in_ready),
      .out_data  (wr_head),
      .out_valid (wr_valid),
      .out_ready (!sleep_s2_reg)
   );

   // memory array, 256K words of 32 bits
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] rd_data_reg;
   logic              rd_valid_reg;

   // self-timed lane writes from the buffer head, sleep stalls them
   always_ff @(posedge clock) begin
      for (int i = 0; i < LANES; i++) begin
         if (wr_valid && !sleep_s2_reg && wr_head.lane_we[i]) begin
            mem[wr_head.addr][i*8 +: 8] <= wr_head.data[i*8 +: 8];
         end
      end
   end

   // read forwards the oldest pending write (buffer head) to the same word, keeps order simple
   wire fwd = wr_valid && (wr_head.addr == cur_addr);
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         rd_data_reg  <= '0;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= is_read;
         if (is_read) rd_data_reg <= fwd ? wr_head.data : mem[cur_addr];
      end
   end

   // output stage: data and double-cycle-deselect enable
   logic drive_hold_reg;   // extra enable stage keeps buffers on
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         dq_out         <= '0;
         dq_oe          <= 1'b0;
         drive_hold_reg <= 1'b0;
         sleep_active   <= 1'b0;
         wr_buffer_full <= 1'b0;
      end else begin
         dq_out         <= rd_data_reg;
         drive_hold_reg <= rd_valid_reg;
         // first clock out of deselect drives regardless of enable
         dq_oe          <= !sleep_s2_reg && ((rd_valid_reg && (oe_s2_reg || first_reg))
                           || (drive_hold_reg && oe_s2_reg));
         sleep_active   <= sleep_s2_reg;
         wr_buffer_full <= !wr_in_ready;
      end
   end

   // checks
   chk_strobe_priority: assert property (@(posedge clock) disable iff (!reset_n)
      proc_addr_strobe_n_ok |-> !ctrl_addr_strobe_n_use) else $error("controller strobe used over processor");
   chk_proc_addr_strobe_n_gated: assert property (@(posedge clock) disable iff (!reset_n)
      (proc_addr_strobe_n_reg && !ce1_reg && !ctrl_addr_strobe_n_reg) |-> !start) else $error("processor strobe not ignored");
   chk_addr_capture: assert property (@(posedge clock) disable iff (!reset_n)
      start |=> base_addr_reg == $past(addr_pin_reg)) else $error("address not captured");
   chk_addr_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !start |=> $stable(base_addr_reg)) else $error("address changed without capture");
   chk_gw_lanes: assert property (@(posedge clock) disable iff (!reset_n)
      gw_reg |-> lanes == 4'hf) else $error("global write not all lanes");
   chk_lane_gate: assert property (@(posedge clock) disable iff (!reset_n)
      (!gw_reg && !lane_en_reg) |-> lanes == 4'h0) else $error("lane written without enable");
   chk_read_pipe: assert property (@(posedge clock) disable iff (!reset_n)
      (is_read && !sleep_s2_reg) ##1 (oe_s2_reg && !sleep_s2_reg) |=> dq_oe) else $error("read not driven");
   chk_dcd_hold: assert property (@(posedge clock) disable iff (!reset_n)
      (drive_hold_reg && oe_s2_reg && !sleep_s2_reg) |=> dq_oe) else $error("deselect hold missing");
   cov_burst_step: cover property (@(posedge clock) disable iff (!reset_n) step ##1 step ##1 step);
   cov_write: cover property (@(posedge clock) disable iff (!reset_n) is_write && gw_reg);
   cov_both_strobes: cover property (@(posedge clock) disable iff (!reset_n) proc_addr_strobe_n_ok && ctrl_addr_strobe_n_reg);
endmodule

/* verif/pdss_ctrl_model.sv */
// controller-side bus model that drives the sram port pins
`timescale 1ns/1ps
module pdss_ctrl_model
   import pdss_pkg::*;
(
   input  wire logic         clock,
   output logic [ADDR_W-1:0] addr_in,
   output logic [DATA_W-1:0] dq_in,
   output logic              proc_addr_strobe_n,
   output logic              ctrl_addr_strobe_n,
   output logic              burst_advance_n,
   output logic [2:0]        sel,                 // primary_n, expand_hi, expand_lo_n
   output logic [3:0]        lane_sel_n,
   output logic              lane_write_enable_n,
   output logic              all_lanes_write_n
);
   // one bus cycle: set after a falling edge, held through the next rising edge
   task automatic drive(input logic [2:0] ctl, input logic [2:0] s, input pdss_wr_t w, input logic [1:0] we);
      @(negedge clock);
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = ctl;
      sel = s;
      addr_in = w.addr;
      lane_sel_n = w.lane_we;                                 // active-low lane selects
      dq_in = w.data;
      {lane_write_enable_n, all_lanes_write_n} = we;
   endtask
   // released lines flip so a stale copy can never look valid
   task automatic idle();
      @(negedge clock);
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
      {lane_write_enable_n, all_lanes_write_n} = 2'h3;
      addr_in = ~addr_in;
      dq_in = ~dq_in;
   endtask
   // quiet bus at time zero
   initial begin
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
      {lane_write_enable_n, all_lanes_write_n} = 2'h3;
      sel = 3'h2;
      lane_sel_n = 4'hf;
      addr_in = 18'h0;
      dq_in = 32'h0;
   end
endmodule

/* verif/pipelined_dcd_sync_sram_port_bench.sv */
// self-checking bench for the pipelined sync sram port
`timescale 1ns/1ps
module pipelined_dcd_sync_sram_port_bench
   import pdss_pkg::*;
;
   // expected read word and the edge count at which it must show
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [31:0]       due;
   } pdss_exp_t;
   logic              clock, reset_n, output_enable_n, sleep_request, burst_interleave, three_enable_variant;
   logic [ADDR_W-1:0] addr_in;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic              dq_oe, sleep_active, wr_buffer_full, proc_n, ctrl_n, adv_n, lane_en_n, all_n;
   logic [2:0]        sel;
   logic [3:0]        ls_n;
   logic [2:0]        rsel = 3'h2;                    // selects used by reads
   logic [31:0]       cyc = 32'h0;                    // rising edges seen
   pdss_exp_t         exp_q[$];
   logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];   // expected array contents
   int                num_errors = 0;
   int                check_count = 0;
   localparam int     LIMIT = 5000;                   // run needs well under a thousand edges

   pdss_top uut (.clock(clock), .reset_n(reset_n), .addr_in(addr_in), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .proc_addr_strobe_n(proc_n), .ctrl_addr_strobe_n(ctrl_n), .burst_advance_n(adv_n),
      .chip_sel_primary_n(sel[2]), .chip_sel_expand_hi(sel[1]), .chip_sel_expand_lo_n(sel[0]),
      .lane0_write_sel_n(ls_n[0]), .lane1_write_sel_n(ls_n[1]), .lane2_write_sel_n(ls_n[2]),
      .lane3_write_sel_n(ls_n[3]), .lane_write_enable_n(lane_en_n), .all_lanes_write_n(all_n),
      .output_enable_n(output_enable_n), .sleep_request(sleep_request), .burst_interleave(burst_interleave),
      .three_enable_variant(three_enable_variant), .sleep_active(sleep_active), .wr_buffer_full(wr_buffer_full));
   pdss_ctrl_model ctrl (.clock(clock), .addr_in(addr_in), .dq_in(dq_in), .proc_addr_strobe_n(proc_n),
      .ctrl_addr_strobe_n(ctrl_n), .burst_advance_n(adv_n), .sel(sel), .lane_sel_n(ls_n),
      .lane_write_enable_n(lane_en_n), .all_lanes_write_n(all_n));

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
      check_count++;
      if (got !== want) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   // edge counter doubles as the hang guard
   always @(posedge clock) begin
      cyc <= cyc + 32'h1;
      if (cyc == LIMIT) begin
         num_errors++;
         report_and_stop();
      end
   end
   // watcher: oldest note must appear exactly at its edge
   always @(posedge clock) begin
      #1;
      if (exp_q.size() > 0 && exp_q[0].due == cyc) begin
         chk({31'h0, dq_oe}, 32'h1);
         chk(dq_out, exp_q[0].data);
         void'(exp_q.pop_front());
      end
   end
   // write through the controller strobe; shadow follows lane rules
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] l, input logic [1:0] we);
      logic [DATA_W-1:0] m;
      m = shadow.exists(a) ? shadow[a] : 32'h0;
      for (int i = 0; i < LANES; i++) begin
         if (!we[0] || (!we[1] && !l[i])) begin
            m[8*i+:8] = d[8*i+:8];
         end
      end
      shadow[a] = m;
      ctrl.drive(3'h5, SEL_ON(), '{a, l, d}, 2'(we));
   endtask
   function automatic logic [2:0] SEL_ON();
      return 3'h2;
   endfunction
   // burst read; hold>0 inserts one stalled advance before that word
   task automatic rd(input logic [ADDR_W-1:0] a, input int n, input int hold, input logic [2:0] ctl,
                     output logic [31:0] due);
      logic [BURST_W-1:0] lo;
      ctrl.drive(ctl, rsel, '{a, 4'hf, 32'(~a)}, 2'h3);
      due = cyc + 32'h3;
      for (int i = 0; i < n; i++) begin
         lo = burst_interleave ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
         if (i > 0 && i == hold) begin
            ctrl.drive(3'h7, rsel, '{~a, 4'hf, 32'h0}, 2'h3);
            due++;
         end
         if (i > 0) begin
            ctrl.drive(3'h6, rsel, '{~a, 4'hf, 32'h0}, 2'h3);
            due++;
         end
         exp_q.push_back('{shadow[{a[ADDR_W-1:2], lo}], due});
      end
      ctrl.idle();
   endtask
   // a start that must not produce any output drive
   task automatic quiet(input logic [2:0] ctl, input logic [2:0] s);
      ctrl.drive(ctl, s, '{18'h0, 4'hf, 32'h0}, 2'h3);
      repeat (6) begin
         ctrl.idle();
         chk({31'h0, dq_oe}, 32'h0);
      end
   endtask

   initial begin
      logic [ADDR_W-1:0] base [8];
      logic [31:0]       due;
      void'($urandom(32'he7bf));
      reset_n = 1'b0;
      output_enable_n = 1'b0;
      sleep_request = 1'b0;
      burst_interleave = 1'b0;
      three_enable_variant = 1'b1;
      repeat (5) @(posedge clock);
      @(negedge clock);
      reset_n = 1'b1;
      repeat (3) ctrl.idle();
      // whole words through global write, lane selects left off
      foreach (base[k]) begin
         base[k] = {13'($urandom), 3'(k), 2'h0};
         for (int i = 0; i < 4; i++) wr(base[k] + 18'(i), $urandom, 4'hf, 2'h2);
      end
      repeat (8) ctrl.idle();
      chk({31'h0, wr_buffer_full}, 32'h0);
      // both burst orders, random start, stall at varying word
      foreach (base[k]) begin
         burst_interleave = k[0];
         repeat (3) ctrl.idle();
         rd(base[k] + 18'($urandom % 4), 4, k % 4, k[1] ? 3'h3 : 3'h5, due);
      end
      repeat (8) ctrl.idle();
      // every lane mask, then selects without the lane enable
      for (int j = 0; j < 16; j++) wr(base[0], $urandom, 4'(j), 2'h1);
      wr(base[1], 32'h0, 4'h0, 2'h3);
      shadow[base[1]] = shadow[base[1]] ^ 32'h0;
      repeat (6) ctrl.idle();
      rd(base[0], 1, 0, 3'h5, due);
      rd(base[1], 1, 0, 3'h5, due);
      // deselect while reading: buffers stay on one extra cycle, then drop
      ctrl.drive(3'h5, 3'h6, '{18'h0, 4'hf, 32'h0}, 2'h3);
      ctrl.idle();
      chk({31'h0, dq_oe}, 32'h1);
      ctrl.idle();
      chk({31'h0, dq_oe}, 32'h1);
      ctrl.idle();
      chk({31'h0, dq_oe}, 32'h1);
      ctrl.idle();
      chk({31'h0, dq_oe}, 32'h0);
      // ignored processor strobe, then two deselect starts
      quiet(3'h3, 3'h6);
      quiet(3'h5, 3'h0);
      quiet(3'h5, 3'h3);
      three_enable_variant = 1'b0;
      rsel = 3'h3;
      // output enable off: first word out of deselect still drives
      output_enable_n = 1'b1;
      repeat (3) ctrl.idle();
      rd(base[2], 1, 0, 3'h5, due);
      repeat (4) ctrl.idle();
      output_enable_n = 1'b0;
      rsel = 3'h2;
      // both strobes with global write: processor strobe reads, no write
      ctrl.drive(3'h1, 3'h2, '{base[3], 4'h0, ~shadow[base[3]]}, 2'h0);
      exp_q.push_back('{shadow[base[3]], cyc + 32'h3});
      repeat (6) ctrl.idle();
      rd(base[3], 1, 0, 3'h5, due);
      // sleep blocks the array write and keeps contents
      sleep_request = 1'b1;
      repeat (4) ctrl.idle();
      chk({31'h0, sleep_active}, 32'h1);
      ctrl.drive(3'h5, 3'h2, '{base[4], 4'h0, 32'h0}, 2'h0);
      repeat (4) ctrl.idle();
      sleep_request = 1'b0;
      repeat (6) ctrl.idle();
      chk({31'h0, sleep_active}, 32'h0);
      rd(base[4], 1, 0, 3'h5, due);
      repeat (8) ctrl.idle();
      report_and_stop();
   end
endmodule
